// *** hdl/alert_mask_fault_queue.sv ***
// Alert generation with source masks, fault queues and fan stall pin
// Operation
// - Alert asserts on any out-of-limit reading unless its source is masked.
// - Latched mode holds alert until status read or ARA; fan and overtemp sources also until back in limits.
// - Comparator mode alert follows limits and releases without software.
// - Config 1 bit 3 picks latched (0) or comparator (1) alert mode.
// - Latched mode sets status on fault; alert only when mask clear.
// - Alert is the OR of every active unmasked source; pin state counts in latched mode only.
// - Mask bit blocks only alert contribution; status still sets.
// - Mask 1 bits 7..3 mask local/remote high/low and diode fault.
// - Mask 2 bits 4..2 mask percent limit, asserted and pin state.
// - Pin state mask has no effect in comparator mode.
// - Mask 3 bit 7 masks fan stall, bit 6 alarm speed.
// - Fan stall output asserts on stall; default pin function.
// - Config 4 bit 7 disables stall output, pin becomes reference.
// - Fault queue only for temperature channels, only in latched mode.
// - Each channel counts alone; alert after programmed consecutive faults.
// - Depth field bits 3:0 decode to 1, 2, 3 or 4, top bit wins.
// - Queue filling ignores the status register bits.
// - Queues reset by ARA, status 1 read or power-on reset.
// - Queue reset releases latched alert even if fault persists.
// - Latched alert reasserts only when a queue refills.
// - Status bits sticky; clear on read only once condition is gone.
`timescale 1ns/1ps
`include "alert_params.svh"
module alert_mask_fault_queue
  import alert_pkg::*;
(
  input  logic mclk,
  input  logic reset,
  input  logic scl_in,
  input  logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input  logic local_done,
  input  logic remote_done,
  input  logic local_high_oor,
  input  logic local_low_oor,
  input  logic remote_high_oor,
  input  logic remote_low_oor,
  input  logic remote_diode_fault,
  input  logic overtemp_pct_oor,
  input  logic overtemp_asserted,
  input  logic overtemp_pin_active,
  input  logic fan_stalled,
  input  logic fan_alarm,
  output logic alert_n,
  output logic fan_stall_n,
  output logic overtemp_ref_sel
);
  reg8_t   cfg1_q;
  reg8_t   cfg4_q;
  reg8_t   fault_queue_depth_q;
  reg8_t   temp_alert_mask_q;
  reg8_t   overtemp_alert_mask_q;
  reg8_t   fan_alert_mask_q;
  reg8_t   temp_status_q;
  reg8_t   overtemp_status_q;
  reg8_t   fan_status_q;
  fq_cnt_t local_cnt_q;
  fq_cnt_t remote_cnt_q;
  fq_cnt_t local_cnt_d;
  fq_cnt_t remote_cnt_d;
  fq_cnt_t depth;
  logic    local_trig_q;
  logic    remote_trig_q;
  reg8_t   reg_addr;
  reg8_t   wr_data;
  reg8_t   rd_data;
  logic    wr_stb;
  logic    rd_stb;
  logic    ara_done;
  reg8_t   temp_raw;
  reg8_t   overtemp_raw;
  reg8_t   fan_raw;
  logic    comp_mode;
  logic    fq_rst;
  logic    local_oor;
  logic    remote_oor;
  logic    local_live;
  logic    remote_live;
  logic    comp_any;
  logic    latch_any;
  logic    overtemp_pin_state_mask;

  // Sticky status: clear only bits whose condition is gone; set wins
  function automatic reg8_t sticky(reg8_t q, reg8_t raw, logic clr);
    return (clr ? (q & raw) : q) | raw;
  endfunction

  // Priority decode of the queue depth field, top bit first
  function automatic fq_cnt_t fq_depth(reg8_t v);
    casez (v[3:0])
      4'b1???: return 3'h4;
      4'b01??: return 3'h3;
      4'b001?: return 3'h2;
      default: return 3'h1;
    endcase
  endfunction

  // One reading on one channel; a same-cycle reset is applied first
  function automatic fq_cnt_t fq_step(fq_cnt_t cnt, logic done,
                                      logic oor, logic rst,
                                      fq_cnt_t lim);
    fq_cnt_t base;
    base = rst ? 3'h0 : cnt;
    if (!done)
      return base;
    if (!oor)
      return 3'h0;
    return (base >= lim) ? lim : base + 3'h1;
  endfunction

  smbus_reg_port u_port (
    .mclk     (mclk),
    .reset    (reset),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .reg_addr (reg_addr),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .rd_data  (rd_data),
    .rd_stb   (rd_stb),
    .ara_done (ara_done)
  );

  // Current condition vectors laid out like the status registers
  assign temp_raw = {local_high_oor, local_low_oor, remote_high_oor,
                     remote_low_oor, remote_diode_fault, 3'h0};
  assign overtemp_raw = {3'h0, overtemp_pct_oor, overtemp_asserted,
                         overtemp_pin_active, 2'h0};
  assign fan_raw = {fan_stalled, fan_alarm, 6'h0};
  assign comp_mode = cfg1_q[`CFG1_COMP_BIT];
  assign overtemp_pin_state_mask = overtemp_alert_mask_q[`ST2_PIN_BIT];
  assign depth = fq_depth(fault_queue_depth_q);
  assign local_oor = local_high_oor | local_low_oor;
  assign remote_oor = remote_high_oor | remote_low_oor | remote_diode_fault;
  // Unmasked temperature sources allowed to trigger the queue alert
  assign local_live = |(temp_raw[7:6] & ~temp_alert_mask_q[7:6]);
  assign remote_live = |(temp_raw[5:3] & ~temp_alert_mask_q[5:3]);
  // Queues restart on ARA or on a read of status 1
  assign fq_rst = ara_done
                | (rd_stb && reg_addr == `STAT1_ADDR);
  assign local_cnt_d = fq_step(local_cnt_q, local_done, local_oor,
                               fq_rst, depth);
  assign remote_cnt_d = fq_step(remote_cnt_q, remote_done, remote_oor,
                                fq_rst, depth);

  // Comparator mode: live OR of unmasked conditions; pin state excluded
  assign comp_any = |(temp_raw & ~temp_alert_mask_q)
                  | (overtemp_pct_oor & ~overtemp_alert_mask_q[4])
                  | (overtemp_asserted & ~overtemp_alert_mask_q[3])
                  | |(fan_raw & ~fan_alert_mask_q);
  // Latched mode: queue triggers for temperatures, sticky status else
  assign latch_any = local_trig_q | remote_trig_q
                   | |(overtemp_status_q & ~overtemp_alert_mask_q
                       & `MASK2_USED)
                   | |(fan_status_q & ~fan_alert_mask_q & `MASK3_USED);

  // Software-written configuration and mask registers
  always_ff @(posedge mclk or posedge reset)
    if (reset)
    begin
      cfg1_q <= `CFG1_RST;
      cfg4_q <= `CFG4_RST;
      fault_queue_depth_q <= `FQ_RST;
      temp_alert_mask_q <= `MASK_RST;
      overtemp_alert_mask_q <= `MASK_RST;
      fan_alert_mask_q <= `MASK_RST;
    end
    else if (wr_stb)
      case (reg_addr)
        `CFG1_ADDR: cfg1_q <= wr_data;
        `CFG4_ADDR: cfg4_q <= wr_data;
        `FQ_ADDR: fault_queue_depth_q <= wr_data;
        `MASK1_ADDR: temp_alert_mask_q <= wr_data & `MASK1_USED;
        `MASK2_ADDR: overtemp_alert_mask_q <= wr_data & `MASK2_USED;
        `MASK3_ADDR: fan_alert_mask_q <= wr_data & `MASK3_USED;
        default: cfg1_q <= cfg1_q;
      endcase

  // Status bits latch every fault regardless of masks
  always_ff @(posedge mclk or posedge reset)
    if (reset)
    begin
      temp_status_q <= 8'h00;
      overtemp_status_q <= 8'h00;
      fan_status_q <= 8'h00;
    end
    else
    begin
      temp_status_q <= sticky(temp_status_q, temp_raw,
                              fq_rst);
      overtemp_status_q <= sticky(overtemp_status_q, overtemp_raw,
                                  ara_done | (rd_stb && reg_addr
                                  == `STAT2_ADDR));
      fan_status_q <= sticky(fan_status_q, fan_raw,
                             ara_done | (rd_stb && reg_addr
                             == `STAT3_ADDR));
    end

  // Consecutive fault counters; inactive in comparator mode
  always_ff @(posedge mclk or posedge reset)
    if (reset)
    begin
      local_cnt_q <= 3'h0;
      remote_cnt_q <= 3'h0;
    end
    else if (comp_mode)
    begin
      local_cnt_q <= 3'h0;
      remote_cnt_q <= 3'h0;
    end
    else
    begin
      local_cnt_q <= local_cnt_d;
      remote_cnt_q <= remote_cnt_d;
    end

  // Queue triggers: a fill sets, a queue reset releases, set wins
  always_ff @(posedge mclk or posedge reset)
    if (reset)
    begin
      local_trig_q <= 1'b0;
      remote_trig_q <= 1'b0;
    end
    else if (comp_mode)
    begin
      local_trig_q <= 1'b0;
      remote_trig_q <= 1'b0;
    end
    else
    begin
      local_trig_q <= (local_trig_q & ~fq_rst)
                    | (local_done & local_live
                       & local_cnt_d == depth);
      remote_trig_q <= (remote_trig_q & ~fq_rst)
                     | (remote_done & remote_live
                        & remote_cnt_d == depth);
    end

  // Alert pin: one OR over all active sources for the chosen mode
  always_ff @(posedge mclk or posedge reset)
    if (reset)
      alert_n <= 1'b1;
    else
      alert_n <= ~(comp_mode ? comp_any : latch_any);

  // Shared pin: stall output by default, reference input when selected
  always_ff @(posedge mclk or posedge reset)
    if (reset)
    begin
      fan_stall_n <= 1'b1;
      overtemp_ref_sel <= 1'b0;
    end
    else
    begin
      fan_stall_n <= cfg4_q[`CFG4_REF_BIT] | ~fan_stalled;
      overtemp_ref_sel <= cfg4_q[`CFG4_REF_BIT];
    end

  // Read data; status 3 bit 0 reports the pin as it stands
  always_comb
    case (reg_addr)
      `CFG1_ADDR: rd_data = cfg1_q;
      `CFG4_ADDR: rd_data = cfg4_q;
      `FQ_ADDR: rd_data = fault_queue_depth_q;
      `MASK1_ADDR: rd_data = temp_alert_mask_q;
      `MASK2_ADDR: rd_data = overtemp_alert_mask_q;
      `MASK3_ADDR: rd_data = fan_alert_mask_q;
      `STAT1_ADDR: rd_data = temp_status_q;
      `STAT2_ADDR: rd_data = overtemp_status_q;
      `STAT3_ADDR: rd_data = {fan_status_q[7:6], 5'h00, ~alert_n};
      default: rd_data = 8'h00;
    endcase

  AST_COMP_RELEASE: assert property (@(posedge mclk)
    disable iff (reset)
    comp_mode && !comp_any |=> alert_n)
    else $error("comparator alert did not release");

  AST_COMP_ASSERT: assert property (@(posedge mclk)
    disable iff (reset)
    comp_mode && comp_any |=> !alert_n)
    else $error("comparator alert did not assert");

  AST_PIN_STATE_IGNORED: assert property (@(posedge mclk)
    disable iff (reset)
    comp_mode && overtemp_pin_active && !overtemp_pin_state_mask
    && !overtemp_pct_oor && !overtemp_asserted
    && temp_raw == 8'h00 && fan_raw == 8'h00 |=> alert_n)
    else $error("pin state raised alert in comparator mode");

  AST_STATUS_SET: assert property (@(posedge mclk)
    disable iff (reset)
    local_high_oor |=> temp_status_q[`ST1_LH_BIT])
    else $error("status bit not set by fault");

  AST_STICKY: assert property (@(posedge mclk) disable iff (reset)
    fan_status_q[`ST3_STALL_BIT] && !ara_done && !rd_stb
    |=> fan_status_q[`ST3_STALL_BIT])
    else $error("sticky status bit dropped");

  AST_QUEUE_IDLE_COMP: assert property (@(posedge mclk)
    disable iff (reset)
    comp_mode |=> local_cnt_q == 3'h0 && remote_cnt_q == 3'h0)
    else $error("fault queue counted in comparator mode");

  AST_QUEUE_RESTART: assert property (@(posedge mclk)
    disable iff (reset)
    local_done && !local_oor |=> local_cnt_q == 3'h0)
    else $error("in-limit reading did not restart count");

  AST_FILL_DEPTH: assert property (@(posedge mclk)
    disable iff (reset)
    $rose(local_trig_q) |-> local_cnt_q == $past(depth))
    else $error("queue fired at wrong depth");

  AST_QUEUE_RELEASE: assert property (@(posedge mclk)
    disable iff (reset)
    fq_rst && !local_done |=> !local_trig_q)
    else $error("queue reset did not release trigger");

  AST_LATCH_HOLD: assert property (@(posedge mclk)
    disable iff (reset)
    !comp_mode && local_trig_q && !fq_rst |=> !alert_n ##1 !alert_n)
    else $error("latched alert released early");

  AST_STALL_OUT: assert property (@(posedge mclk)
    disable iff (reset)
    !cfg4_q[`CFG4_REF_BIT] && fan_stalled |=> !fan_stall_n)
    else $error("stall output missing");

  AST_REF_MODE: assert property (@(posedge mclk)
    disable iff (reset)
    cfg4_q[`CFG4_REF_BIT] |=> fan_stall_n && overtemp_ref_sel)
    else $error("stall output not disabled");

  AST_MASKED_NO_TRIG: assert property (@(posedge mclk)
    disable iff (reset)
    !local_trig_q && local_done && !local_low_oor
    && temp_alert_mask_q[`ST1_LH_BIT] |=> !local_trig_q)
    else $error("masked local channel fired its queue");
endmodule // alert_mask_fault_queue

// *** hdl/alert_params.svh ***
// Register offsets, field positions and reset values for the alert block
`ifndef ALERT_PARAMS_SVH
`define ALERT_PARAMS_SVH
`define CFG1_ADDR      8'h01
`define CFG4_ADDR      8'h04
`define FQ_ADDR        8'h06
`define MASK1_ADDR     8'h08
`define MASK2_ADDR     8'h09
`define MASK3_ADDR     8'h0a
`define STAT1_ADDR     8'h4f
`define STAT2_ADDR     8'h50
`define STAT3_ADDR     8'h51
`define CFG1_RST       8'h00
`define CFG4_RST       8'h00
`define FQ_RST         8'h01
`define MASK_RST       8'h00
`define CFG1_COMP_BIT  3
`define CFG4_REF_BIT   7
`define ST1_LH_BIT     7
`define ST1_LL_BIT     6
`define ST1_RH_BIT     5
`define ST1_RL_BIT     4
`define ST1_RD_BIT     3
`define ST2_PCT_BIT    4
`define ST2_ASRT_BIT   3
`define ST2_PIN_BIT    2
`define ST3_STALL_BIT  7
`define ST3_ALARM_BIT  6
`define ST3_ALERT_BIT  0
`define MASK1_USED     8'hf8
`define MASK2_USED     8'h1c
`define MASK3_USED     8'hc0
`define SMB_DEV_ADDR   7'h2c
`define SMB_ARA_ADDR   7'h0c
`endif

// *** hdl/alert_pkg.sv ***
// Shared types for the alert block
package alert_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [2:0] fq_cnt_t;
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_PTR, S_WDATA, S_ACK, S_RDATA, S_RACK
  } smb_state_t;
endpackage

// *** hdl/smbus_reg_port.sv ***
// Two-wire serial register port with alert response address support
`timescale 1ns/1ps
`include "alert_params.svh"
module smbus_reg_port
  import alert_pkg::*;
(
  input  logic  mclk,
  input  logic  reset,
  input  logic  scl_in,
  input  logic  sda_in,
  output logic  sda_out,
  output logic  sda_oe,
  output reg8_t reg_addr,
  output logic  wr_stb,
  output reg8_t wr_data,
  input  reg8_t rd_data,
  output logic  rd_stb,
  output logic  ara_done
);
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  smb_state_t st_q;
  smb_state_t next_q;
  logic [2:0] cnt_q;
  reg8_t      sh_q;
  reg8_t      ptr_q;
  logic       rd_q;
  logic       ara_q;
  logic       ackd_q;
  reg8_t      b;
  reg8_t      tx;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;

  // Two-stage sync plus one history stage; stage 0 feeds stage 1 only
  always_ff @(posedge mclk or posedge reset)
    if (reset)
    begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end
    else
    begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
    end

  // Bus events seen on the synchronised copies
  assign rise  = scl_s[1] & ~scl_s[2];
  assign fall  = ~scl_s[1] & scl_s[2];
  assign start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
  assign b     = {sh_q[6:0], sda_s[1]};
  assign tx    = ara_q ? {`SMB_DEV_ADDR, 1'b0} : rd_data;
  assign reg_addr = ptr_q;  // Pointer kept apart from write data

  // Open-drain data only ever pulls low
  always_ff @(posedge mclk or posedge reset)
    if (reset)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;

  // Byte engine: address, pointer, write data, read data, acks
  always_ff @(posedge mclk or posedge reset)
    if (reset)
    begin
      st_q <= S_IDLE;
      next_q <= S_IDLE;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      ara_q <= 1'b0;
      ackd_q <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
      ptr_q <= 8'h00;
      rd_stb <= 1'b0;
      ara_done <= 1'b0;
    end
    else
    begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      ara_done <= 1'b0;
      if (start)
      begin
        st_q <= S_ADDR;
        cnt_q <= 3'h0;
        sda_oe <= 1'b0;
        ara_q <= 1'b0;
      end
      else if (stop)
      begin
        st_q <= S_IDLE;
        sda_oe <= 1'b0;
      end
      else
        case (st_q)
          S_ADDR, S_PTR, S_WDATA:
            if (rise)
            begin
              sh_q <= b;
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7)
              begin
                ackd_q <= 1'b0;
                st_q <= S_ACK;
                rd_q <= 1'b0;
                next_q <= S_WDATA;
                if (st_q == S_ADDR)
                begin
                  if (b[7:1] == `SMB_DEV_ADDR)
                  begin
                    rd_q <= b[0];
                    next_q <= S_PTR;
                  end
                  else if (b == {`SMB_ARA_ADDR, 1'b1})
                  begin
                    rd_q <= 1'b1;
                    ara_q <= 1'b1;
                  end
                  else
                    st_q <= S_IDLE;  // Not ours: stay off the bus
                end
                else if (st_q == S_PTR)
                  ptr_q <= b;        // Pointer held for later access
                else
                begin
                  wr_stb <= 1'b1;
                  wr_data <= b;
                end
              end
            end
          S_ACK:
            if (fall)
            begin
              if (!ackd_q)
              begin
                sda_oe <= 1'b1;
                ackd_q <= 1'b1;
              end
              else if (rd_q)
              begin
                sh_q <= tx;
                sda_oe <= ~tx[7];
                cnt_q <= 3'h0;
                st_q <= S_RDATA;
                rd_stb <= ~ara_q;
              end
              else
              begin
                sda_oe <= 1'b0;
                cnt_q <= 3'h0;
                st_q <= next_q;
              end
            end
          S_RDATA:
            if (rise)
            begin
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7)
                st_q <= S_RACK;
            end
            else if (fall)
            begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe <= ~sh_q[6];
            end
          S_RACK:
            if (fall)
              sda_oe <= 1'b0;
            else if (rise)
            begin
              ara_done <= ara_q;
              rd_q <= 1'b1;
              ackd_q <= 1'b1;
              st_q <= sda_s[1] ? S_IDLE : S_ACK;
            end
          S_IDLE:
            cnt_q <= 3'h0;
          default:
            st_q <= S_IDLE;
        endcase
    end
endmodule // smbus_reg_port

// *** verif/smbus_host.sv ***
// Bus host model driving the serial clock and the data pull-down
`timescale 1ns/1ps
module smbus_host
(
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // Idle bus: clock parked high, data released to the pull-up
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Quarter of the 320 ns bus period, stepped on falling mclk edges
  task automatic q;
    repeat (2) @(negedge mclk);
  endtask

  // Start or repeated start; data falls while the clock is high
  task automatic start_c;
    sda_pull = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask

  // Stop: data rises while the clock is high, clock then stands still
  task automatic stop_c;
    sda_pull = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b0;
    q();
  endtask

  // Eight bits MSB first plus the ack slot; a 1 releases the wire
  task automatic byte_c(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_pull = ~tx[i];
      q();
      scl = 1'b1;
      q();
      rx[i] = sda; // Sampled mid-high, well after the device settles
      q();
      scl = 1'b0;
      q();
    end
  endtask
endmodule // smbus_host

// *** verif/alert_mask_fault_queue_tb.sv ***
// Self-checking bench for the alert block driven through a bus host model
`timescale 1ns/1ps
`include "alert_params.svh"
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, e, a); end end
module alert_mask_fault_queue_tb
  import alert_pkg::*;
;
  logic       mclk, reset, ldone, rdone, scl, sda_pull, sda;
  logic       sda_out, sda_oe, alert_n, fan_stall_n, ref_sel;
  logic [9:0] src;
  logic [8:0] r;
  reg8_t      d;
  int         n_fail, checks;
  reg8_t      used [3] = '{`MASK1_USED, `MASK2_USED, `MASK3_USED};
  reg8_t      fq_code [4] = '{8'h00, 8'h02, 8'h05, 8'h0f};
  int         fq_len [4] = '{1, 2, 3, 4};
  // Only the pin-state source stays silent in comparator mode
  localparam logic [9:0] CMP_N = 10'h004;

  // Open-drain data wire with pull-up: low when either side pulls
  assign sda = ~((sda_oe & ~sda_out) | sda_pull);

  alert_mask_fault_queue uut (
    .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .local_done(ldone),
    .remote_done(rdone), .local_high_oor(src[9]), .local_low_oor(src[8]),
    .remote_high_oor(src[7]), .remote_low_oor(src[6]),
    .remote_diode_fault(src[5]), .overtemp_pct_oor(src[4]),
    .overtemp_asserted(src[3]), .overtemp_pin_active(src[2]),
    .fan_stalled(src[1]), .fan_alarm(src[0]), .alert_n(alert_n),
    .fan_stall_n(fan_stall_n), .overtemp_ref_sel(ref_sel));

  smbus_host h (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic w2;
    repeat (2) @(negedge mclk);
  endtask

  // One reading; the trailing edge keeps back-to-back pulses distinct
  task automatic pulse(input logic rem);
    ldone = ~rem;
    rdone = rem;
    @(negedge mclk);
    ldone = 1'b0;
    rdone = 1'b0;
    @(negedge mclk);
  endtask

  task automatic wr(input reg8_t p, input reg8_t v);
    h.start_c();
    h.byte_c({`SMB_DEV_ADDR, 1'b0, 1'b1}, r);
    h.byte_c({p, 1'b1}, r);
    h.byte_c({v, 1'b1}, r);
    `CHK("data ack", 1'b0, r[0])
    h.stop_c();
  endtask

  // Pointer write, repeated start, one byte read with a closing nack
  task automatic rd(input reg8_t p, output reg8_t v);
    h.start_c();
    h.byte_c({`SMB_DEV_ADDR, 1'b0, 1'b1}, r);
    h.byte_c({p, 1'b1}, r);
    h.start_c();
    h.byte_c({`SMB_DEV_ADDR, 1'b1, 1'b1}, r);
    h.byte_c(9'h1ff, r);
    v = r[8:1];
    h.stop_c();
  endtask

  task automatic ara(output reg8_t v);
    h.start_c();
    h.byte_c({`SMB_ARA_ADDR, 1'b1, 1'b1}, r);
    h.byte_c(9'h1ff, r);
    v = r[8:1];
    h.stop_c();
  endtask

  task automatic conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog sized well past the expected run of about 0.6 ms
  initial
  begin
    #3000000;
    n_fail++;
    conclude();
  end

  initial
  begin
    reset = 1'b1;
    ldone = 1'b0;
    rdone = 1'b0;
    src = '0;
    n_fail = 0;
    checks = 0;
    repeat (16) @(negedge mclk);
    `CHK("reset outs", 3'b110, {alert_n, fan_stall_n, ref_sel})
    `CHK("reset bus", 2'b00, {sda_oe, sda_out})
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    rd(`FQ_ADDR, d);
    `CHK("fq reset", 8'h01, d)
    // Mask resets and reserved bits that store as zero
    for (int i = 0; i < 3; i++)
    begin
      rd(reg8_t'(`MASK1_ADDR + i), d);
      `CHK("mask reset", 8'h00, d)
      wr(reg8_t'(`MASK1_ADDR + i), 8'hff);
      rd(reg8_t'(`MASK1_ADDR + i), d);
      `CHK("mask used", used[i], d)
      wr(reg8_t'(`MASK1_ADDR + i), 8'h00);
    end
    rd(8'h7e, d);
    `CHK("unmapped", 8'h00, d)
    h.start_c();
    h.byte_c({7'h33, 1'b0, 1'b1}, r);
    `CHK("foreign nack", 1'b1, r[0])
    h.stop_c();
    // Depth rows: fill, release on queue reset with fault held, refill
    for (int i = 0; i < 4; i++)
    begin
      wr(`FQ_ADDR, fq_code[i]);
      rd(`STAT1_ADDR, d);
      if (fq_len[i] > 1)
      begin
        src[9] = 1'b1;
        pulse(1'b0);
        src[9] = 1'b0;
        pulse(1'b0);
      end
      src[9] = 1'b1;
      for (int k = 0; k < 2; k++)
      begin
        repeat (fq_len[i] - 1) pulse(1'b0);
        w2();
        `CHK("queue short", 1'b1, alert_n)
        pulse(1'b0);
        w2();
        `CHK("queue full", 1'b0, alert_n)
        if (i % 2 == 1)
        begin
          ara(d);
          `CHK("ara addr", {`SMB_DEV_ADDR, 1'b0}, d)
        end
        else
          rd(`STAT1_ADDR, d);
        `CHK("queue reset", 1'b1, alert_n)
      end
      src[9] = 1'b0;
      rd(`STAT1_ADDR, d);
    end
    // Separate counts per channel at depth 2
    wr(`FQ_ADDR, 8'h02);
    rd(`STAT1_ADDR, d);
    src = 10'h220;
    pulse(1'b0);
    pulse(1'b1);
    w2();
    `CHK("split count", 1'b1, alert_n)
    pulse(1'b1);
    w2();
    `CHK("remote fill", 1'b0, alert_n)
    src = '0;
    rd(`STAT1_ADDR, d);
    `CHK("remote clr", 1'b1, alert_n)
    wr(`FQ_ADDR, 8'h00);
    // Masked local channel: status still sets, queue stays silent
    wr(`MASK1_ADDR, 8'h80);
    src[9] = 1'b1;
    pulse(1'b0);
    w2();
    `CHK("masked queue", 1'b1, alert_n)
    src[9] = 1'b0;
    rd(`STAT1_ADDR, d);
    `CHK("masked stat1", 8'h80, d)
    wr(`MASK1_ADDR, 8'h00);
    // Latched fan alarm, then the host's mask-and-poll service
    src[0] = 1'b1;
    w2();
    `CHK("latched low", 1'b0, alert_n)
    src[0] = 1'b0;
    w2();
    `CHK("latched hold", 1'b0, alert_n)
    rd(`STAT3_ADDR, d);
    `CHK("stat3 alert", 8'h41, d)
    `CHK("read release", 1'b1, alert_n)
    wr(`MASK3_ADDR, 8'h40);
    src[0] = 1'b1;
    w2();
    `CHK("masked", 1'b1, alert_n)
    rd(`STAT3_ADDR, d);
    `CHK("masked stat", 8'h40, d)
    src[0] = 1'b0;
    rd(`STAT3_ADDR, d);
    `CHK("sticky", 8'h40, d)
    rd(`STAT3_ADDR, d);
    `CHK("cleared", 8'h00, d)
    wr(`MASK3_ADDR, 8'h00);
    // Stall output and its hand-over to the reference function
    wr(`MASK3_ADDR, 8'h80);
    src[1] = 1'b1;
    w2();
    `CHK("stall out", 2'b01, {fan_stall_n, alert_n})
    wr(`CFG4_ADDR, 8'h80);
    `CHK("ref pin", 2'b11, {ref_sel, fan_stall_n})
    wr(`CFG4_ADDR, 8'h00);
    `CHK("stall back", 1'b0, fan_stall_n)
    src[1] = 1'b0;
    rd(`STAT3_ADDR, d);
    wr(`MASK3_ADDR, 8'h00);
    // Comparator rows: every source but pin state follows its level without software
    wr(`CFG1_ADDR, 8'h08);
    for (int i = 0; i < 10; i++)
    begin
      src = 10'h001 << i;
      w2();
      `CHK("cmp alert", CMP_N[i], alert_n)
      src = '0;
      w2();
      `CHK("cmp release", 1'b1, alert_n)
    end
    src = 10'h009;
    w2();
    src = 10'h001;
    w2();
    `CHK("or hold", 1'b0, alert_n)
    src = '0;
    w2();
    `CHK("or release", 1'b1, alert_n)
    // Mid-run reset: alert idles at once, then latched mode is back
    src = 10'h001;
    w2();
    reset = 1'b1;
    w2();
    `CHK("mid reset", 1'b1, alert_n)
    reset = 1'b0;
    src = '0;
    repeat (4) @(negedge mclk);
    rd(`CFG1_ADDR, d);
    `CHK("cfg1 reset", `CFG1_RST, d)
    src[0] = 1'b1;
    w2();
    src[0] = 1'b0;
    w2();
    `CHK("latched again", 1'b0, alert_n)
    conclude();
  end
endmodule // alert_mask_fault_queue_tb
